// >>> src/ubg_clock_gen.sv
/*
 * Baud clock generator of a serial transceiver: rate generator, fractional in
 * asynchronous operation only, for asynchronous, synchronous master and master SPI operation, and
 * sampling of the transfer clock pin in synchronous slave operation.
 * Assumes all inputs except transfer_clock_pin are synchronous to clock; settings change only while
 * no transfer is running. Shift logic and buffers sit outside.
 */
// Overview of operation
// [RQ1] Five clock modes: async normal/double, sync master/slave, SPI.
// [RQ2] Internal generator except in synchronous slave mode.
// [RQ3] Period setting is a 12-bit unsigned value.
// [RQ4] Signed scale -7..+7 trims the rate finely.
// [RQ5] Software keeps scale zero when period is zero.
// [RQ6] Software bounds two-to-scale by half frame cycles.
// [RQ7] Normal async rate uses 16 samples per bit.
// [RQ8] Double speed async uses 8 samples per bit.
// [RQ9] Synchronous master and SPI: clock over 2(period+1).
// [RQ10] Software replaces positive scale by larger period.
// [RQ11] Slave mode samples pin with peripheral clock.
// [RQ12] Peer keeps pin clock below quarter rate.
// [RQ13] Peer slows clock when jittery or uneven duty.
// [RQ14] SPI mode turns off async-only logic.
// [RQ15] Double speed receiver takes 8 samples per bit.
// [RQ16] Down-counter reloads from period, ticks on reload.
`timescale 1ns/100ps
module ubg_clock_gen (
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	input  wire logic                         generator_enable,
	input  wire logic [1:0]                   mode_select,
	input  wire logic                         double_speed_select,
	input  wire logic [ubg_pkg::UBG_PERIOD_W-1:0] baud_period_setting,
	input  wire logic [ubg_pkg::UBG_SCALE_W-1:0]  baud_scale_setting,
	input  wire logic                         transfer_clock_pin,
	output logic                              sample_tick,
	output logic                              bit_tick,
	output logic                              transfer_clock_out,
	output logic                              transfer_clock_oe,
	output logic                              clock_rise_tick,
	output logic                              clock_fall_tick,
	output logic                              async_logic_enable,
	output logic                              samples_per_bit_8
);
	import ubg_pkg::*;

	// ****************************************
	// Mode decode
	// ****************************************
	ubg_mode_e mode_reg;
	ubg_mode_e mode_next;

	// The two-bit select maps onto four one-hot modes; double speed splits async in two.
	always_comb begin
		case (mode_select)
			UBG_SEL_ASYNC:       mode_next = UBG_MODE_ASYNC;        // see [RQ1]
			UBG_SEL_SYNC_MASTER: mode_next = UBG_MODE_SYNC_MASTER;
			UBG_SEL_SYNC_SLAVE:  mode_next = UBG_MODE_SYNC_SLAVE;
			UBG_SEL_MASTER_SPI:  mode_next = UBG_MODE_MASTER_SPI;
			default:             mode_next = UBG_MODE_ASYNC;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= UBG_MODE_ASYNC;
		end else begin
			mode_reg <= mode_next;
		end
	end

	logic is_async;
	logic is_master_sync;
	logic is_slave;
	assign is_async       = (mode_reg == UBG_MODE_ASYNC);
	assign is_master_sync = (mode_reg == UBG_MODE_SYNC_MASTER) || (mode_reg == UBG_MODE_MASTER_SPI); // see [RQ9]
	assign is_slave       = (mode_reg == UBG_MODE_SYNC_SLAVE);

	// ****************************************
	// Fractional reload computation
	// ****************************************
	// Scale magnitude and sign; the synchronous modes ignore scale entirely.
	logic                    scale_neg;
	logic [2:0]              scale_mag;
	logic [UBG_FRAC_W-1:0]   frac_mask;
	logic [UBG_FRAC_W-1:0]   frac_part;
	logic [UBG_FRAC_W:0]     frac_sum;
	logic                    frac_carry;
	logic [UBG_COUNT_W-1:0]  reload_value;
	logic [UBG_FRAC_W-1:0]   frac_acc_reg;
	logic [UBG_FRAC_W-1:0]   frac_acc_next;
	logic [UBG_COUNT_W-1:0]  period_plus_one;
	logic                    main_tick;

	// A scale of -8 is outside the legal range and is treated as -7.
	assign scale_neg = baud_scale_setting[UBG_SCALE_W-1];                                     // see [RQ4]
	assign scale_mag = scale_neg ? ((baud_scale_setting == 4'h8) ? 3'h7 : 3'((~baud_scale_setting) + 4'h1))
	                             : baud_scale_setting[2:0];
	assign frac_mask = UBG_FRAC_W'((9'h001 << scale_mag) - 9'h001);
	assign frac_part = UBG_FRAC_W'(baud_period_setting) & frac_mask;
	assign frac_sum  = {1'b0, frac_acc_reg} + {1'b0, frac_part};
	assign frac_carry = ((frac_sum >> scale_mag) != '0);
	assign period_plus_one = UBG_COUNT_W'(baud_period_setting) + 20'h0_0001;                  // see [RQ3]

	// Positive scale stretches each tick by 2^scale; negative scale shortens the period
	// to period/2^k + 1 on average by carrying the dropped fraction between ticks.
	always_comb begin
		reload_value  = UBG_COUNT_W'(baud_period_setting);                                   // see [RQ16]
		frac_acc_next = frac_acc_reg;
		if (is_async && !scale_neg) begin
			reload_value = UBG_COUNT_W'((period_plus_one << scale_mag) - 20'h0_0001);        // see [RQ7]
		end else if (is_async && scale_neg) begin
			reload_value = UBG_COUNT_W'(baud_period_setting >> scale_mag) + UBG_COUNT_W'(frac_carry);
			if (main_tick) begin
				frac_acc_next = frac_sum[UBG_FRAC_W-1:0] & frac_mask;
			end
		end
		if (!generator_enable) begin
			frac_acc_next = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frac_acc_reg <= '0;
		end else begin
			frac_acc_reg <= frac_acc_next;
		end
	end

	// ****************************************
	// Dividers
	// ****************************************
	logic                  gen_clear;
	logic                  ovs_tick;
	logic [UBG_OVS_W-1:0]  ovs_last;

	// Slave mode leaves the generator idle; it would only waste power there.
	assign gen_clear = !generator_enable || is_slave;                                        // see [RQ2]
	assign ovs_last  = double_speed_select ? UBG_OVS_DOUBLE_LAST : UBG_OVS_NORMAL_LAST;     // see [RQ8] see [RQ15]

	// Rate counter stepping every peripheral clock.
	ubg_tick_divider #(.WIDTH(UBG_COUNT_W)) u_rate_div (
		.clock      (clock),
		.rst_n      (rst_n),
		.clear      (gen_clear),
		.step       (1'b1),
		.load_value (reload_value),
		.tick       (main_tick)
	);

	// Oversample counter: 16 or 8 rate ticks make one asynchronous bit.
	ubg_tick_divider #(.WIDTH(UBG_OVS_W)) u_ovs_div (
		.clock      (clock),
		.rst_n      (rst_n),
		.clear      (gen_clear || !is_async),
		.step       (main_tick),
		.load_value (ovs_last),
		.tick       (ovs_tick)
	);

	// ****************************************
	// Transfer clock pin sampling
	// ****************************************
	// Two flops before any edge logic keep a slow or ragged pin from reaching the
	// edge detector half-settled; the peer must hold each phase two cycles.
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= transfer_clock_pin;                                              // see [RQ11]
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;                                                    // see [RQ12]
		end
	end

	// ****************************************
	// Output stage
	// ****************************************
	logic sample_tick_reg;
	logic sample_tick_next;
	logic bit_tick_reg;
	logic bit_tick_next;
	logic clk_out_reg;
	logic clk_out_next;
	logic clk_oe_reg;
	logic clk_oe_next;
	logic rise_reg;
	logic rise_next;
	logic fall_reg;
	logic fall_next;
	logic async_en_reg;
	logic async_en_next;
	logic ovs8_reg;
	logic ovs8_next;
	logic tick_dly_reg;
	logic tick_dly_next;

	// Master clock toggles on every rate tick, so a full period is 2(period+1) cycles.
	// Data changes on the rising edge and is sampled on the falling edge, which is when
	// bit_tick fires in the synchronous modes.
	always_comb begin
		sample_tick_next = 1'b0;
		tick_dly_next    = main_tick;
		bit_tick_next    = 1'b0;
		rise_next        = 1'b0;
		fall_next        = 1'b0;
		clk_out_next     = clk_out_reg;
		clk_oe_next      = is_master_sync && generator_enable;
		async_en_next    = is_async;                                                          // see [RQ14]
		ovs8_next        = is_async && double_speed_select;                                   // see [RQ15]
		if (!generator_enable) begin
			clk_out_next = 1'b0;
		end else if (is_async) begin
			// The oversample tick lags the rate tick by one flop, so the rate tick is
			// delayed as well; otherwise bit_tick would land one cycle after its sample.
			sample_tick_next = tick_dly_reg;                                                  // see [RQ7]
			bit_tick_next    = ovs_tick;
		end else if (is_master_sync) begin
			if (main_tick) begin
				clk_out_next  = !clk_out_reg;                                                 // see [RQ9]
				rise_next     = !clk_out_reg;
				fall_next     = clk_out_reg;
				bit_tick_next = clk_out_reg;
			end
		end else begin
			clk_out_next  = 1'b0;
			rise_next     = pin_sync_reg && !pin_prev_reg;                                    // see [RQ11]
			fall_next     = !pin_sync_reg && pin_prev_reg;
			bit_tick_next = fall_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sample_tick_reg <= 1'b0;
			bit_tick_reg    <= 1'b0;
			clk_out_reg     <= 1'b0;
			clk_oe_reg      <= 1'b0;
			rise_reg        <= 1'b0;
			fall_reg        <= 1'b0;
			async_en_reg    <= 1'b1;
			ovs8_reg        <= 1'b0;
			tick_dly_reg    <= 1'b0;
		end else begin
			sample_tick_reg <= sample_tick_next;
			bit_tick_reg    <= bit_tick_next;
			clk_out_reg     <= clk_out_next;
			clk_oe_reg      <= clk_oe_next;
			rise_reg        <= rise_next;
			fall_reg        <= fall_next;
			async_en_reg    <= async_en_next;
			ovs8_reg        <= ovs8_next;
			tick_dly_reg    <= tick_dly_next;
		end
	end

	// All outputs come straight from the flops above.
	assign sample_tick        = sample_tick_reg;
	assign bit_tick           = bit_tick_reg;
	assign transfer_clock_out = clk_out_reg;
	assign transfer_clock_oe  = clk_oe_reg;
	assign clock_rise_tick    = rise_reg;
	assign clock_fall_tick    = fall_reg;
	assign async_logic_enable = async_en_reg;
	assign samples_per_bit_8  = ovs8_reg;

endmodule // ubg_clock_gen

// >>> shared/ubg_pkg.sv
/*
 * Constants shared by the baud clock generator: setting widths, mode codes,
 * oversampling counts and counter sizes.
 * Assumes a single peripheral clock of 40 MHz with no other clock domain.
 */
package ubg_pkg;

	// ****************************************
	// Setting widths
	// ****************************************
	localparam int UBG_PERIOD_W   = 12;  // Period setting, 0 through 4095.
	localparam int UBG_SCALE_W    = 4;   // Signed scale setting, -7 through +7.
	localparam int UBG_FRAC_W     = 8;   // Fraction accumulator for negative scale.
	localparam int UBG_COUNT_W    = 20;  // Holds (4095 + 1) << 7 minus one.
	localparam int UBG_OVS_W      = 4;   // Oversample counter width.
	localparam int UBG_CLK_PERIOD_NS = 25;

	// ****************************************
	// Oversampling, counted as reload values (count minus one)
	// ****************************************
	localparam logic [3:0] UBG_OVS_NORMAL_LAST = 4'hF;  // 16 samples per bit.
	localparam logic [3:0] UBG_OVS_DOUBLE_LAST = 4'h7;  // 8 samples per bit.

	// ****************************************
	// Mode select codes on the mode input
	// ****************************************
	localparam logic [1:0] UBG_SEL_ASYNC       = 2'h0;
	localparam logic [1:0] UBG_SEL_SYNC_MASTER = 2'h1;
	localparam logic [1:0] UBG_SEL_SYNC_SLAVE  = 2'h2;
	localparam logic [1:0] UBG_SEL_MASTER_SPI  = 2'h3;

	// Active clock generation mode, one-hot.
	typedef enum logic [3:0] {
		UBG_MODE_ASYNC       = 4'b0001,
		UBG_MODE_SYNC_MASTER = 4'b0010,
		UBG_MODE_SYNC_SLAVE  = 4'b0100,
		UBG_MODE_MASTER_SPI  = 4'b1000
	} ubg_mode_e;

endpackage

// >>> src/ubg_tick_divider.sv
/*
 * Down-counting divider: counts step pulses and emits a registered tick
 * each time the count passes through zero, then reloads.
 * Assumes step and clear are synchronous to clock.
 */
`timescale 1ns/100ps
module ubg_tick_divider #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             step,
	input  wire logic [WIDTH-1:0] load_value,
	output logic                  tick
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic             tick_reg;
	logic             tick_next;

	// ****************************************
	// Counter next state
	// ****************************************
	// Reload happens in the zero cycle, so a load value of N gives N+1 steps per tick.
	always_comb begin
		count_next = count_reg;
		tick_next  = 1'b0;
		if (clear) begin
			count_next = load_value;
		end else if (step) begin
			if (count_reg == '0) begin
				count_next = load_value;
				tick_next  = 1'b1;
			end else begin
				count_next = count_reg - 1'b1;
			end
		end
	end

	// Registers only.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
			tick_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg  <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule // ubg_tick_divider

// >>> verification/ubg_clock_gen_chk.sv
/* Port checker of the baud clock generator, bound into ubg_clock_gen.
   Assumes settings and modes change only while generator_enable is low. */
`timescale 1ns/100ps
module ubg_clock_gen_chk
	import ubg_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic                    generator_enable,
	input wire logic [1:0]              mode_select,
	input wire logic                    double_speed_select,
	input wire logic [UBG_PERIOD_W-1:0] baud_period_setting,
	input wire logic [UBG_SCALE_W-1:0]  baud_scale_setting,
	input wire logic                    transfer_clock_pin,
	input wire logic                    sample_tick,
	input wire logic                    bit_tick,
	input wire logic                    transfer_clock_out,
	input wire logic                    transfer_clock_oe,
	input wire logic                    clock_rise_tick,
	input wire logic                    clock_fall_tick,
	input wire logic                    async_logic_enable,
	input wire logic                    samples_per_bit_8
);
	// ****************************************
	// Helper counters
	// ****************************************
	logic [19:0] gap_reg, gap_next, tog_reg, tog_next;
	logic [1:0]  hold_reg, hold_next, mode_reg;
	logic        seen_reg, seen_next, tseen_reg, tseen_next, out_reg;
	logic        steady, master, flip;
	logic [2:0]  kmag;
	// History is dropped whenever the generator stops, so a new setting never meets an old gap.
	always_comb begin
		flip       = transfer_clock_out != out_reg;
		gap_next   = sample_tick ? 20'h0_0000 : gap_reg + 20'h0_0001;
		seen_next  = generator_enable & (seen_reg | sample_tick);
		tog_next   = flip ? 20'h0_0000 : tog_reg + 20'h0_0001;
		tseen_next = generator_enable & (tseen_reg | flip);
		hold_next  = (mode_select != mode_reg) ? 2'h0 : ((hold_reg == 2'h3) ? 2'h3 : hold_reg + 2'h1);
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{gap_reg, tog_reg, hold_reg, mode_reg} <= '0;
			{seen_reg, tseen_reg, out_reg} <= '0;
		end else begin
			{gap_reg, tog_reg, hold_reg, mode_reg} <= {gap_next, tog_next, hold_next, mode_select};
			{seen_reg, tseen_reg, out_reg} <= {seen_next, tseen_next, transfer_clock_out};
		end
	end
	// The mode must sit still a few cycles before outputs are judged against it.
	assign steady = hold_reg == 2'h3 && mode_select == mode_reg;
	// Magnitude of a negative scale setting.
	assign kmag   = 3'(4'h0 - baud_scale_setting);
	assign master = steady && (mode_select == UBG_SEL_SYNC_MASTER || mode_select == UBG_SEL_MASTER_SPI);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_slave_oe; steady && mode_select == UBG_SEL_SYNC_SLAVE |-> !transfer_clock_oe; endproperty
	a_slave_oe: assert property (p_slave_oe) else $error("pin driven in slave mode");
	property p_master_oe; master && generator_enable && $past(generator_enable) |-> transfer_clock_oe; endproperty
	a_master_oe: assert property (p_master_oe) else $error("pin not driven in master mode");
	property p_async_off; steady && mode_select != UBG_SEL_ASYNC |-> !async_logic_enable; endproperty
	a_async_off: assert property (p_async_off) else $error("async logic left on");
	property p_spb8;
		steady && mode_select == UBG_SEL_ASYNC && double_speed_select && $past(double_speed_select)
			|-> samples_per_bit_8;
	endproperty
	a_spb8: assert property (p_spb8) else $error("double speed sampling not flagged");
	property p_bit_on_sample; steady && mode_select == UBG_SEL_ASYNC && bit_tick |-> sample_tick; endproperty
	a_bit_on_sample: assert property (p_bit_on_sample) else $error("bit tick off sample tick");
	property p_rate;
		steady && mode_select == UBG_SEL_ASYNC && seen_reg && sample_tick && !baud_scale_setting[3]
			|-> gap_reg == ((20'(baud_period_setting) + 20'h0_0001) << baud_scale_setting[2:0]) - 20'h0_0001;
	endproperty
	a_rate: assert property (p_rate) else $error("sample tick interval wrong");
	// A negative scale gives intervals of period/2^k plus one, or one cycle more.
	property p_rate_frac;
		steady && mode_select == UBG_SEL_ASYNC && seen_reg && sample_tick && baud_scale_setting[3]
			|-> gap_reg >= 20'(baud_period_setting >> kmag) && gap_reg <= 20'(baud_period_setting >> kmag) + 20'h0_0001;
	endproperty
	a_rate_frac: assert property (p_rate_frac) else $error("fractional interval out of range");
	property p_toggle;
		master && tseen_reg && flip && generator_enable && $past(generator_enable)
			|-> tog_reg == 20'(baud_period_setting);
	endproperty
	a_toggle: assert property (p_toggle) else $error("master clock half period wrong");
	property p_rise_mark; master && generator_enable && $rose(transfer_clock_out) |-> clock_rise_tick; endproperty
	a_rise_mark: assert property (p_rise_mark) else $error("rise tick missing");
	property p_fall_mark; master && generator_enable && $fell(transfer_clock_out) |-> clock_fall_tick; endproperty
	a_fall_mark: assert property (p_fall_mark) else $error("fall tick missing");
	property p_slave_edge;
		steady && mode_select == UBG_SEL_SYNC_SLAVE && generator_enable && $rose(transfer_clock_pin)
			|-> ##[2:4] clock_rise_tick;
	endproperty
	a_slave_edge: assert property (p_slave_edge) else $error("pin edge not seen");
	property p_idle; !generator_enable && !$past(generator_enable) && !$past(generator_enable, 2) |-> !sample_tick;
	endproperty
	a_idle: assert property (p_idle) else $error("tick while disabled");
	c_double: cover property (samples_per_bit_8 && bit_tick);
	c_master: cover property (transfer_clock_oe && clock_rise_tick);
	c_slave: cover property (!transfer_clock_oe && clock_rise_tick);
endmodule // ubg_clock_gen_chk

bind ubg_clock_gen ubg_clock_gen_chk ubg_clock_gen_chk_i (.*);

// >>> verification/ubg_peer_clock.sv
/* Remote peer that drives the transfer clock pin in slave operation.
   Assumes it shares the reset of the bench; the clock stands low outside transfers. */
`timescale 1ns/100ps
module ubg_peer_clock #(
	parameter int HALF = 3
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic active,
	output logic      pin
);
	int count;
	// Even duty and a period of 2*HALF peripheral cycles, above four, so each phase is sampled twice.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n || !active) begin
			pin   <= 1'b0;
			count <= 0;
		end else if (count == HALF - 1) begin
			pin   <= !pin;
			count <= 0;
		end else begin
			count <= count + 1;
		end
	end
endmodule // ubg_peer_clock

// >>> verification/usart_baud_clock_generator_tb.sv
/* Self-checking bench of the baud clock generator with a peer on the clock pin.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("FAIL at %0t: got %h expected %h", $time, (a), (b)); end end
module usart_baud_clock_generator_tb;
	import ubg_pkg::*;
	logic        clock = 1'b0, rst_n = 1'b0, ge = 1'b0, ds = 1'b0, pin, peer_on = 1'b0;
	logic        st, bt, co, oe, rt, ft, ae, s8;
	logic [1:0]  mode = 2'h0;
	logic [11:0] per = 12'h000;
	logic [3:0]  sc = 4'h0;
	int          bad_count = 0, tests_run = 0, n;
	always #(UBG_CLK_PERIOD_NS / 2.0) clock = !clock;
	ubg_clock_gen ubg_clock_gen_i (.clock(clock), .rst_n(rst_n), .generator_enable(ge), .mode_select(mode),
		.double_speed_select(ds), .baud_period_setting(per), .baud_scale_setting(sc), .transfer_clock_pin(pin),
		.sample_tick(st), .bit_tick(bt), .transfer_clock_out(co), .transfer_clock_oe(oe), .clock_rise_tick(rt),
		.clock_fall_tick(ft), .async_logic_enable(ae), .samples_per_bit_8(s8));
	ubg_peer_clock ubg_peer_clock_i (.clock(clock), .rst_n(rst_n), .active(peer_on), .pin(pin));
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Counts cycles until the chosen pulse; a pulse that never comes ends the run.
	task wt(input int sel, output int cnt);
		cnt = 0;
		repeat (20000) begin
			@(posedge clock);
			#1;
			if ((sel == 0 ? st : (sel == 1 ? bt : (sel == 2 ? rt : ft))) === 1'b1) return;
			cnt++;
		end
		bad_count++;
		complete_run();
	endtask
	// Settings change only with the generator stopped, as the generator expects.
	task start(input logic [1:0] m, input logic d, input logic [11:0] p, input logic [3:0] s);
		@(posedge clock);
		ge <= 1'b0;
		repeat (3) @(posedge clock);
		{mode, ds, per, sc} <= {m, d, p, s};
		repeat (3) @(posedge clock);
		ge <= 1'b1;
	endtask
	// A negative scale is judged over 2^k intervals, across which the carried fraction adds up exactly.
	task t_async(input logic [11:0] p, input logic [3:0] s, input logic d, input bit bits);
		int reps, gap, sum;
		reps = s[3] ? 1 << (16 - int'(s)) : 1;
		gap  = s[3] ? int'(p) + reps : (int'(p) + 1) << s;
		sum  = 0;
		start(UBG_SEL_ASYNC, d, p, s);
		wt(0, n);
		repeat (reps) begin
			wt(0, n);
			sum += n + 1;
		end
		`CHK(sum, gap)
		if (bits) begin
			wt(1, n);
			wt(1, n);
			`CHK(n + 1, gap * (d ? 8 : 16) / reps)
		end
		`CHK(s8, d)
		`CHK(ae, 1'b1)
	endtask
	task t_sync(input logic [1:0] m, input logic [11:0] p);
		start(m, 1'b0, p, 4'h3);
		wt(2, n);
		`CHK(co, 1'b1)
		wt(2, n);
		`CHK(n + 1, 2 * (int'(p) + 1))
		wt(3, n);
		`CHK(n + 1, int'(p) + 1)
		`CHK({bt, co}, 2'b10)
		`CHK(oe, 1'b1)
		`CHK(ae, 1'b0)
	endtask
	task t_slave;
		start(UBG_SEL_SYNC_SLAVE, 1'b0, 12'h001, 4'h0);
		peer_on <= 1'b1;
		wt(2, n);
		wt(2, n);
		`CHK(n + 1, 6)
		wt(3, n);
		`CHK(n + 1, 3)
		`CHK({bt, oe}, 2'b10)
		peer_on <= 1'b0;
	endtask
	task t_off;
		int hits;
		hits = 0;
		@(posedge clock);
		ge <= 1'b0;
		repeat (3) @(posedge clock);
		repeat (40) begin
			@(posedge clock);
			#1;
			if (st !== 1'b0) hits++;
		end
		`CHK(hits, 0)
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_async(12'h002, 4'h0, 1'b0, 1'b1);
		t_async(12'h001, 4'h1, 1'b0, 1'b1);
		t_async(12'h004, 4'hF, 1'b0, 1'b1);
		t_async(12'h005, 4'hF, 1'b0, 1'b1);
		t_async(12'h3FF, 4'h9, 1'b0, 1'b0);
		t_async(12'h001, 4'h7, 1'b0, 1'b0);
		t_async(12'h07F, 4'h0, 1'b0, 1'b0);
		t_async(12'hFFF, 4'h0, 1'b1, 1'b0);
		t_async(12'h000, 4'h0, 1'b1, 1'b1);
		t_off();
		t_sync(UBG_SEL_SYNC_MASTER, 12'h001);
		t_sync(UBG_SEL_MASTER_SPI, 12'h001);
		t_sync(UBG_SEL_SYNC_MASTER, 12'hFFF);
		t_slave();
		complete_run();
	end
endmodule // usart_baud_clock_generator_tb
